// *** dsr_pkg.sv ***
`default_nettype none
package dsr_pkg;
   // ***************
   // Clock and averaging
   // ***************
   localparam int CLK_HZ = 10000000;
   localparam int AVG_PERIODS = 8;
   localparam int TOT_W = 20;
   localparam logic [TOT_W-1:0] TOT_MAX = 20'h20000;
   localparam int TOL_SHIFT = 5;
   localparam int LOW_HZ [4] = '{697, 770, 852, 941};
   localparam int HIGH_HZ [4] = '{1209, 1336, 1477, 1633};
   // ***************
   // Guard times
   // ***************
   localparam int TONE_ON_US = 40000;
   localparam int TONE_OFF_US = 40000;
   localparam int TONE_ON_CYC = TONE_ON_US * (CLK_HZ / 1000000);
   localparam int TONE_OFF_CYC = TONE_OFF_US * (CLK_HZ / 1000000);
   localparam int GUARD_W = 21;
   // ***************
   // Readout and buffering
   // ***************
   localparam int CODE_W = 4;
   localparam logic [2:0] PULSES = 3'h4;
   localparam int FIFO_DEPTH = 4;
   localparam int SYNC_W = 5;
   localparam int S_LOW = 0;
   localparam int S_HIGH = 1;
   localparam int S_ENERGY = 2;
   localparam int S_ACK = 3;
   localparam int S_PD = 4;
   // ***************
   // Types
   // ***************
   typedef struct packed {
      logic valid;
      logic [1:0] idx;
   } dsr_tone_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_QUAL = 2'b01,
      ST_ON = 2'b10,
      ST_DROP = 2'b11
   } dsr_steer_t;
   // ***************
   // Functions
   // ***************
   function automatic dsr_tone_t dsr_classify(input logic [TOT_W-1:0] tot, input logic high);
      dsr_tone_t r;
      int nom;
      r = '0;
      nom = 0;
      for (int i = 0; i < 4; i++) begin
         nom = (AVG_PERIODS * CLK_HZ) / (high ? HIGH_HZ[i] : LOW_HZ[i]);
         if (int'(tot) >= nom - (nom >>> TOL_SHIFT) && int'(tot) <= nom + (nom >>> TOL_SHIFT)) begin
            r.valid = 1'b1;
            r.idx = 2'(i);
         end
      end
      return r;
   endfunction
   function automatic logic [CODE_W-1:0] dsr_code(input logic [1:0] lo, input logic [1:0] hi);
      case ({lo, hi})
         4'h0: return 4'h1;
         4'h1: return 4'h2;
         4'h2: return 4'h3;
         4'h3: return 4'hD;
         4'h4: return 4'h4;
         4'h5: return 4'h5;
         4'h6: return 4'h6;
         4'h7: return 4'hE;
         4'h8: return 4'h7;
         4'h9: return 4'h8;
         4'hA: return 4'h9;
         4'hB: return 4'hF;
         4'hC: return 4'hB;
         4'hD: return 4'hA;
         4'hE: return 4'hC;
         default: return 4'h0;
      endcase
   endfunction
endpackage
`default_nettype wire

// *** dsr_receiver.sv ***
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - After steering rises, four readout pulses shift the four code bits out serially.
// - First readout pulse rising edge captures the whole 4-bit code before shifting.
// - Readout pulse input has a weak internal pull-down.
// - Power-down holds the steering output low.
// - High on power-down input enters power-down.
// - Power-down input has an internal pull-down.
// - Early variant raises steering once both tone groups are valid.
// - Early variant drops steering as soon as dual-tone validity is lost.
// - Delayed variant raises steering after tone-present guard time fully elapses.
// - Delayed steering falls after a full tone-absent guard time, or at once on power-down.
// - Validated digit becomes a 4-bit code by table lookup.
// - Tone validity comes from averaging the squared group signals.
// - Least significant bit goes out first, then ascending bits.
// - Incomplete pulse sequence blocks capture of a new code.
// - Pulses beyond four are ignored until the next steering rise.
// - Serial output carries energy except from first rise to fourth fall; it is held low in power-down.

// ***************
// Code buffer
// ***************
module dsr_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic push, pop;

   assign in_ready = cnt_r != CW'(DEPTH);
   assign out_valid = cnt_r != '0;
   assign out_data = mem_r[rp_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      wp_nxt = push ? PW'((32'(wp_r) + 1) % DEPTH) : wp_r;
      rp_nxt = pop ? PW'((32'(rp_r) + 1) % DEPTH) : rp_r;
      cnt_nxt = cnt_r + CW'(push) - CW'(pop);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end
endmodule // dsr_fifo

// ***************
// Tone group averager
// ***************
module dsr_tone_avg #(
   parameter logic HIGH_GRP = 1'b0
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Control and squared tone
   input wire logic clear,
   input wire logic sq_s,
   // Result
   output dsr_pkg::dsr_tone_t tone
);
   import dsr_pkg::*;
   logic sq_d_r;
   logic [TOT_W-1:0] tot_r, tot_nxt;
   logic [3:0] per_r, per_nxt;
   dsr_tone_t tone_r, tone_nxt;
   logic edge_s;

   assign edge_s = sq_s && !sq_d_r;
   assign tone = tone_r;

   always_comb begin
      tot_nxt = tot_r;
      per_nxt = per_r;
      tone_nxt = tone_r;
      if (clear) begin
         tot_nxt = '0;
         per_nxt = '0;
         tone_nxt = '0;
      end else if (tot_r == TOT_MAX) begin
         tot_nxt = '0;
         per_nxt = '0;
         tone_nxt = '0;
      end else if (edge_s) begin
         tot_nxt = '0;
         if (per_r == 4'(AVG_PERIODS)) begin
            tone_nxt = dsr_classify(tot_r + 1'b1, HIGH_GRP);
            per_nxt = 4'h1;
         end else begin
            if (per_r != 4'h0) begin
               tot_nxt = tot_r + 1'b1;
            end
            per_nxt = per_r + 4'h1;
         end
      end else if (per_r != 4'h0) begin
         tot_nxt = tot_r + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sq_d_r <= 1'b0;
         tot_r <= '0;
         per_r <= '0;
         tone_r <= '0;
      end else begin
         sq_d_r <= sq_s;
         tot_r <= tot_nxt;
         per_r <= per_nxt;
         tone_r <= tone_nxt;
      end
   end
endmodule // dsr_tone_avg

// ***************
// Receiver back end
// ***************
module dsr_receiver #(
   parameter logic EARLY_VARIANT = 1'b0,
   parameter int TONE_ON_CYCLES = dsr_pkg::TONE_ON_CYC,
   parameter int TONE_OFF_CYCLES = dsr_pkg::TONE_OFF_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Front end
   input wire logic low_sq_in,
   input wire logic high_sq_in,
   input wire logic energy_in,
   // Controller link
   input wire logic readout_pulse_in,
   input wire logic power_down_in,
   output logic readout_pull_dn,
   output logic power_down_pull_dn,
   output logic early_steer,
   output logic delayed_steer,
   output logic serial_out_cp
);
   import dsr_pkg::*;
   logic [SYNC_W-1:0] sync1_r, sync2_r;
   dsr_tone_t lo, hi;
   logic pd, early_cond, steer_rise, ack_d_r, ack_rise, ack_fall, capture;
   dsr_steer_t st_r, st_nxt;
   logic [GUARD_W-1:0] gcnt_r, gcnt_nxt;
   logic steer_r, steer_nxt, steer_d_r;
   logic pend_r, pend_nxt;
   logic [CODE_W-1:0] code_pend_r, code_pend_nxt;
   logic fifo_in_ready, fifo_out_valid;
   logic [CODE_W-1:0] fifo_out_data;
   logic [2:0] pcnt_r, pcnt_nxt;
   logic sel_r, sel_nxt, armed_r, armed_nxt, so_r, so_nxt;
   logic [CODE_W-1:0] sh_r, sh_nxt;

   // ***************
   // Input synchronisers
   // ***************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {power_down_in, readout_pulse_in, energy_in, high_sq_in, low_sq_in};
         sync2_r <= sync1_r;
      end
   end

   assign readout_pull_dn = 1'b1;
   assign power_down_pull_dn = 1'b1;
   assign pd = sync2_r[S_PD];

   // ***************
   // Tone detection
   // ***************
   dsr_tone_avg #(.HIGH_GRP(1'b0)) u_low (
      .clk_sys(clk_sys),
      .rst(rst),
      .clear(pd),
      .sq_s(sync2_r[S_LOW]),
      .tone(lo)
   );
   dsr_tone_avg #(.HIGH_GRP(1'b1)) u_high (
      .clk_sys(clk_sys),
      .rst(rst),
      .clear(pd),
      .sq_s(sync2_r[S_HIGH]),
      .tone(hi)
   );
   assign early_cond = lo.valid && hi.valid;

   // ***************
   // Steering
   // ***************
   always_comb begin
      st_nxt = st_r;
      gcnt_nxt = gcnt_r;
      case (st_r)
         ST_IDLE: begin
            gcnt_nxt = '0;
            if (early_cond) begin
               st_nxt = ST_QUAL;
            end
         end
         ST_QUAL: begin
            if (!early_cond) begin
               st_nxt = ST_IDLE;
            end else if (gcnt_r == GUARD_W'(TONE_ON_CYCLES - 1)) begin
               st_nxt = ST_ON;
            end else begin
               gcnt_nxt = gcnt_r + 1'b1;
            end
         end
         ST_ON: begin
            gcnt_nxt = '0;
            if (!early_cond) begin
               st_nxt = ST_DROP;
            end
         end
         ST_DROP: begin
            if (early_cond) begin
               st_nxt = ST_ON;
            end else if (gcnt_r == GUARD_W'(TONE_OFF_CYCLES - 1)) begin
               st_nxt = ST_IDLE;
            end else begin
               gcnt_nxt = gcnt_r + 1'b1;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
            gcnt_nxt = '0;
         end
      endcase
      if (pd) begin
         st_nxt = ST_IDLE;
         gcnt_nxt = '0;
      end
      if (EARLY_VARIANT) begin
         steer_nxt = early_cond && !pd;
      end else begin
         steer_nxt = (st_nxt == ST_ON || st_nxt == ST_DROP) && !pd;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_r <= ST_IDLE;
         gcnt_r <= '0;
         steer_r <= 1'b0;
         steer_d_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         gcnt_r <= gcnt_nxt;
         steer_r <= steer_nxt;
         steer_d_r <= steer_r;
      end
   end

   assign early_steer = EARLY_VARIANT ? steer_r : 1'b0;
   assign delayed_steer = EARLY_VARIANT ? 1'b0 : steer_r;
   assign steer_rise = steer_r && !steer_d_r;

   // ***************
   // Code lookup and buffering
   // ***************
   always_comb begin
      pend_nxt = pend_r && !fifo_in_ready;
      code_pend_nxt = code_pend_r;
      if (steer_rise) begin
         pend_nxt = 1'b1;
         code_pend_nxt = dsr_code(lo.idx, hi.idx);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pend_r <= 1'b0;
         code_pend_r <= '0;
      end else begin
         pend_r <= pend_nxt;
         code_pend_r <= code_pend_nxt;
      end
   end

   dsr_fifo #(.WIDTH(CODE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_valid(pend_r),
      .in_ready(fifo_in_ready),
      .in_data(code_pend_r),
      .out_valid(fifo_out_valid),
      .out_ready(capture),
      .out_data(fifo_out_data)
   );

   // ***************
   // Serial readout
   // ***************
   assign ack_rise = sync2_r[S_ACK] && !ack_d_r;
   assign ack_fall = !sync2_r[S_ACK] && ack_d_r;
   assign capture = ack_rise && armed_r && pcnt_r == 3'h0 && fifo_out_valid && !pd;

   always_comb begin
      pcnt_nxt = pcnt_r;
      sel_nxt = sel_r;
      sh_nxt = sh_r;
      armed_nxt = armed_r;
      if (capture) begin
         sh_nxt = fifo_out_data;
         pcnt_nxt = 3'h1;
         sel_nxt = 1'b1;
      end else if (ack_rise && pcnt_r != 3'h0 && pcnt_r != PULSES) begin
         sh_nxt = {1'b0, sh_r[CODE_W-1:1]};
         pcnt_nxt = pcnt_r + 3'h1;
      end else if (ack_fall && pcnt_r == PULSES) begin
         pcnt_nxt = 3'h0;
         sel_nxt = 1'b0;
         armed_nxt = 1'b0;
      end
      if (steer_rise) begin
         armed_nxt = 1'b1;
      end
      if (pd) begin
         pcnt_nxt = 3'h0;
         sel_nxt = 1'b0;
      end
      so_nxt = pd ? 1'b0 : (sel_nxt ? sh_nxt[0] : sync2_r[S_ENERGY]);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ack_d_r <= 1'b0;
         pcnt_r <= '0;
         sel_r <= 1'b0;
         sh_r <= '0;
         armed_r <= 1'b0;
         so_r <= 1'b0;
      end else begin
         ack_d_r <= sync2_r[S_ACK];
         pcnt_r <= pcnt_nxt;
         sel_r <= sel_nxt;
         sh_r <= sh_nxt;
         armed_r <= armed_nxt;
         so_r <= so_nxt;
      end
   end

   assign serial_out_cp = so_r;

   // ***************
   // Checks
   // ***************
   logic [GUARD_W-1:0] on_run_r, off_run_r;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         on_run_r <= '0;
         off_run_r <= '0;
      end else begin
         on_run_r <= early_cond ? (&on_run_r ? on_run_r : on_run_r + 1'b1) : '0;
         off_run_r <= !early_cond ? (&off_run_r ? off_run_r : off_run_r + 1'b1) : '0;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   pd_steer_low_a: assert property (pd |=> !early_steer && !delayed_steer)
      else $error("steering high in power-down");
   pd_serial_low_a: assert property (pd |=> !serial_out_cp)
      else $error("serial output high in power-down");
   early_rise_a: assert property (EARLY_VARIANT && early_cond && !pd |=> early_steer)
      else $error("early steering missed tone pair");
   early_drop_a: assert property (EARLY_VARIANT && $fell(early_cond) |=> !early_steer)
      else $error("early steering held after tone loss");
   dly_rise_a: assert property (!EARLY_VARIANT && $rose(delayed_steer) |-> on_run_r >= GUARD_W'(TONE_ON_CYCLES))
      else $error("delayed steering rose before guard time");
   dly_fall_a: assert property (!EARLY_VARIANT && $fell(delayed_steer) && !$past(pd)
      |-> off_run_r >= GUARD_W'(TONE_OFF_CYCLES))
      else $error("delayed steering fell before absent guard");
   code_lookup_a: assert property (steer_rise |=> code_pend_r == dsr_code($past(lo.idx), $past(hi.idx)))
      else $error("latched code does not match lookup");
   first_bit_a: assert property (capture |=> serial_out_cp == $past(fifo_out_data[0]) ##1 sel_r)
      else $error("first bit is not code bit zero");
   shift_seq_a: assert property (ack_rise && !pd && pcnt_r inside {3'h1, 3'h2, 3'h3}
      |=> serial_out_cp == $past(sh_r[1]))
      else $error("serial bit order wrong");
   no_recapture_a: assert property (pcnt_r != 3'h0 || !armed_r |-> !capture)
      else $error("capture during open sequence");
   energy_mux_a: assert property (!sel_nxt && !pd |=> serial_out_cp == $past(sync2_r[S_ENERGY]))
      else $error("serial output not carrying energy");
   seq_end_a: assert property (ack_fall && pcnt_r == PULSES && !pd |=> pcnt_r == 3'h0 && !sel_r)
      else $error("sequence did not close at fourth fall");
endmodule // dsr_receiver
`default_nettype wire

// *** dsr_ctrl_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ***************
// Controller that clocks the serial readout
// ***************
module dsr_ctrl_model (
   // Command from the bench
   input wire logic go,
   input wire logic [2:0] n_pulses,
   // Link
   input wire logic serial_in,
   output logic ack_pin,
   // Result
   output logic [3:0] bits,
   output logic done
);
   initial begin
      ack_pin = 1'b0;
      bits = 4'h0;
      done = 1'b0;
   end
   // Pulses of 400 ns every 800 ns, phase unrelated to the system clock
   always @(posedge go) begin
      done = 1'b0;
      bits = 4'h0;
      #137;
      for (int i = 0; i < int'(n_pulses); i++) begin
         ack_pin = 1'b1;
         #400;
         ack_pin = 1'b0;
         #150;
         bits[i % 4] = serial_in;
         #250;
      end
      ack_pin = 1'b0;
      done = 1'b1;
   end
endmodule // dsr_ctrl_model
`default_nettype wire

// *** dsr_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
   import dsr_pkg::*;
   // ***************
   // Stimulus and observed signals
   // ***************
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic energy_in = 1'b0;
   logic power_down_in = 1'b0;
   logic go = 1'b0;
   logic [2:0] n_pulses = 3'h4;
   logic [1:0] sq = 2'h0;
   int half [2] = '{0, 0};
   int cnt [2] = '{0, 0};
   wire logic readout_pin;
   wire logic readout_pull_dn;
   wire logic power_down_pull_dn;
   wire logic early_steer;
   wire logic delayed_steer;
   wire logic serial_out_cp;
   wire logic early_e;
   wire logic delayed_e;
   wire logic [3:0] bits;
   wire logic done;
   int err_total = 0;
   int compares = 0;
   int row_lo [4] = '{941, 852, 941, 852};
   int row_hi [4] = '{1633, 1633, 1209, 1336};
   logic [3:0] row_code [4] = '{4'h0, 4'hF, 4'hB, 4'h8};
   // ***************
   // Instances
   // ***************
   dsr_receiver #(.EARLY_VARIANT(1'b0), .TONE_ON_CYCLES(20), .TONE_OFF_CYCLES(20)) uut (
      .clk_sys(clk_sys), .rst(rst), .low_sq_in(sq[0]), .high_sq_in(sq[1]), .energy_in(energy_in),
      .readout_pulse_in(readout_pin), .power_down_in(power_down_in), .readout_pull_dn(readout_pull_dn),
      .power_down_pull_dn(power_down_pull_dn), .early_steer(early_steer), .delayed_steer(delayed_steer),
      .serial_out_cp(serial_out_cp));
   dsr_receiver #(.EARLY_VARIANT(1'b1), .TONE_ON_CYCLES(20), .TONE_OFF_CYCLES(20)) uut_early (
      .clk_sys(clk_sys), .rst(rst), .low_sq_in(sq[0]), .high_sq_in(sq[1]), .energy_in(energy_in),
      .readout_pulse_in(readout_pin), .power_down_in(power_down_in), .readout_pull_dn(),
      .power_down_pull_dn(), .early_steer(early_e), .delayed_steer(delayed_e), .serial_out_cp());
   dsr_ctrl_model ctrl (
      .go(go), .n_pulses(n_pulses), .serial_in(serial_out_cp), .ack_pin(readout_pin), .bits(bits),
      .done(done));
   // ***************
   // Clock and tone squares
   // ***************
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      for (int g = 0; g < 2; g++) begin
         if (half[g] == 0) begin
            sq[g] <= 1'b0;
         end else if (cnt[g] >= half[g] - 1) begin
            cnt[g] <= 0;
            sq[g] <= ~sq[g];
         end else begin
            cnt[g] <= cnt[g] + 1;
         end
      end
   end
   // ***************
   // Tasks
   // ***************
   task automatic final_report();
      $display("checks %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wait_steer(input logic lvl);
      int k;
      k = 0;
      while (delayed_steer !== lvl && k < 400000) begin
         @(posedge clk_sys);
         k++;
      end
      if (k >= 400000) begin
         err_total++;
         $display("[ERR] steering expected %b seen %b", lvl, delayed_steer);
         final_report();
      end
   endtask
   task automatic readout(input logic [2:0] np);
      int k;
      k = 0;
      n_pulses <= np;
      go <= 1'b1;
      @(posedge clk_sys);
      while (done !== 1'b1 && k < 200) begin
         @(posedge clk_sys);
         k++;
      end
      go <= 1'b0;
      if (k >= 200) begin
         err_total++;
         $display("[ERR] readout done expected 1 seen %b", done);
         final_report();
      end
      @(posedge clk_sys);
   endtask
   // ***************
   // Main sequence
   // ***************
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("pulls and steering", 4'hC, {readout_pull_dn, power_down_pull_dn, early_steer, delayed_steer});
      energy_in <= 1'b1;
      repeat (5) @(posedge clk_sys);
      chk("energy pass", 4'h1, {3'h0, serial_out_cp});
      $display("test idle done");
      // Digits through the full path; each code waits one digit in the buffer across a power-down
      for (int i = 0; i < 4; i++) begin
         half[0] <= 0;
         half[1] <= 0;
         power_down_in <= 1'b1;
         repeat (4) @(posedge clk_sys);
         power_down_in <= 1'b0;
         repeat (3) @(posedge clk_sys);
         wait_steer(1'b0);
         energy_in <= (row_code[i] == 4'h0);
         half[0] <= 5000000 / row_lo[i];
         half[1] <= 5000000 / row_hi[i];
         wait_steer(1'b1);
         chk("steer pair", 4'h5, {early_steer, early_e, delayed_e, delayed_steer});
         if (i > 0) begin
            readout(3'h4);
            chk("buffered code", row_code[i-1], bits);
         end
         repeat (5) @(posedge clk_sys);
         chk("energy after code", {3'h0, energy_in}, {3'h0, serial_out_cp});
         $display("test digit %0d done", i);
      end
      // Pulses after a complete sequence show only energy
      energy_in <= 1'b1;
      repeat (5) @(posedge clk_sys);
      readout(3'h2);
      chk("extra pulses", 4'h3, bits);
      $display("test extra pulses done");
      // Power-down with the tone still present
      energy_in <= 1'b1;
      power_down_in <= 1'b1;
      repeat (5) @(posedge clk_sys);
      repeat (8) begin
         @(negedge clk_sys);
         chk("outputs in power-down", 4'h0, {early_e, serial_out_cp, early_steer, delayed_steer});
      end
      power_down_in <= 1'b0;
      $display("test power-down done");
      final_report();
   end
endmodule // tb
`default_nettype wire
